// File: logic/ifp_ctrl.sv
// self_programming flash controller: registers, unlock, page buffer, sequencer
// Summary of operation
// [RQ1] pages of 32 words; single-word reads
// [RQ2] software erases a page before writing
// [RQ3] buffer loads only while erase/write enabled
// [RQ4] write start bit clears when write done
// [RQ5] read refused while read enable is low
// [RQ6] read start bit clears when read done
// [RQ7] address 11:5 page, 4:0 word offset
// [RQ8] buffer clear bit self-clears when done
// [RQ9] high data write loads word, bumps address
// [RQ10] address holds at last word of page
// [RQ11] buffer cleared after every page write
// [RQ12] software clears buffer and rewrites on error
// [RQ13] enable flag hardware-set only; zero disables
// [RQ14] modes: write, erase, read, unlock
// [RQ15] no erase/write unless unlocked
// [RQ16] unlock bit starts timer, clears on expiry
// [RQ17] software writes key before timer expires
// [RQ18] six key bytes, wrong key stays locked
// [RQ19] software never sets three start bits together
// [RQ20] cpu stalls while an operation runs
// [RQ21] software waits stable sub clock, completion
// [RQ22] timing select picks erase/write durations
// [RQ23] 55h into reset key resets the chip
// [RQ24] erase tags addresses via high data writes
// [RQ25] read word lands in data pair zero
// [RQ26] operation ends after duration and array done
`timescale 1ns/10ps
module ifp_ctrl #(
  parameter int ERASE_FAST = ifp_pkg::ERASE_CYC_FAST,
  parameter int WRITE_FAST = ifp_pkg::WRITE_CYC_FAST,
  parameter int ERASE_SLOW = ifp_pkg::ERASE_CYC_SLOW,
  parameter int WRITE_SLOW = ifp_pkg::WRITE_CYC_SLOW
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // cpu register port
  input wire ifp_pkg::ifp_bus_t bus,
  input wire logic [3:0] rd_addr,
  output logic [7:0] rd_data,
  output logic cpu_stall,
  output logic chip_rst_req,
  // flash array
  output ifp_pkg::ifp_arr_req_t arr_req,
  output logic [15:0] arr_wdata,
  output logic [31:0] arr_tag,
  input wire logic arr_busy,
  input wire logic [15:0] arr_rdata
);
  typedef enum logic [2:0] {IFP_IDLE, IFP_ERASE, IFP_WRITE, IFP_READ, IFP_CLEAR} ifp_state_t;

  ifp_state_t state_r;
  logic ew_en_r;
  logic [2:0] mode_r;
  logic unlock_r;
  logic wr_start_r;
  logic rd_en_r;
  logic rd_start_r;
  logic tsel_r;
  logic buf_clr_r;
  logic [7:0] chip_key_r;
  logic [11:0] addr_r;
  logic [7:0] dat_lo_r [4];
  logic [7:0] dat_hi_r [4];
  logic [15:0] wbuf_r [ifp_pkg::PAGE_WORDS];
  logic [31:0] tag_r;
  logic [4:0] ptr_r;
  logic [6:0] ulk_cnt_r;
  logic [7:0] rd_data_r;
  logic stall_r;
  logic chip_rst_r;
  ifp_pkg::ifp_arr_req_t req_r;
  logic [15:0] wdata_r;
  logic [1:0] rd_cnt_r;
  logic tmr_load;
  logic [17:0] tmr_count;
  logic tmr_expired;
  logic w_ctrl;
  logic w_aux;
  logic w_hi0;
  logic go_erase;
  logic go_write;
  logic go_read;
  logic key_ok;
  logic [17:0] dur_erase;
  logic [17:0] dur_write;

  // register write decode
  assign w_ctrl = bus.wr & (bus.addr == ifp_pkg::ADDR_CTRL_MAIN);
  assign w_aux = bus.wr & (bus.addr == ifp_pkg::ADDR_CTRL_AUX);
  assign w_hi0 = bus.wr & (bus.addr == ifp_pkg::ADDR_DAT0_HI);

  // operation launch conditions
  assign go_erase = w_ctrl & bus.wdata[ifp_pkg::BIT_WR_START] & ew_en_r
    & (bus.wdata[6:4] == ifp_pkg::MODE_ERASE); // [RQ15] [RQ14]
  assign go_write = w_ctrl & bus.wdata[ifp_pkg::BIT_WR_START] & ew_en_r
    & (bus.wdata[6:4] == ifp_pkg::MODE_WRITE); // [RQ15] [RQ14]
  assign go_read = w_ctrl & bus.wdata[ifp_pkg::BIT_RD_START] & bus.wdata[ifp_pkg::BIT_RD_EN]
    & (bus.wdata[6:4] == ifp_pkg::MODE_READ); // [RQ5] [RQ14]

  // unlock key compare over data pairs one to three
  assign key_ok = (dat_lo_r[1] == ifp_pkg::KEY_D1L) & (dat_lo_r[2] == ifp_pkg::KEY_D2L)
    & (dat_lo_r[3] == ifp_pkg::KEY_D3L) & (dat_hi_r[1] == ifp_pkg::KEY_D1H)
    & (dat_hi_r[2] == ifp_pkg::KEY_D2H) & (dat_hi_r[3] == ifp_pkg::KEY_D3H); // [RQ18]

  // duration selection
  assign dur_erase = tsel_r ? 18'(ERASE_SLOW) : 18'(ERASE_FAST); // [RQ22]
  assign dur_write = tsel_r ? 18'(WRITE_SLOW) : 18'(WRITE_FAST); // [RQ22]
  assign tmr_load = (state_r == IFP_IDLE) & (go_erase | go_write);
  assign tmr_count = go_erase ? dur_erase : dur_write;

  // minimum erase/write duration
  ifp_op_timer #(
    .W(18)
  ) u_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  // operation sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= IFP_IDLE;
    end else begin
      unique case (state_r)
        IFP_IDLE: begin
          if (go_erase) begin
            state_r <= IFP_ERASE;
          end else if (go_write) begin
            state_r <= IFP_WRITE;
          end else if (go_read) begin
            state_r <= IFP_READ;
          end else if (w_aux & bus.wdata[ifp_pkg::BIT_BUF_CLR]) begin
            state_r <= IFP_CLEAR;
          end
        end
        IFP_ERASE, IFP_WRITE: begin
          if (tmr_expired & ~arr_busy) begin
            state_r <= IFP_IDLE; // [RQ26]
          end
        end
        IFP_READ: begin
          if (rd_cnt_r == 2'(ifp_pkg::READ_CYC - 1)) begin
            state_r <= IFP_IDLE;
          end
        end
        IFP_CLEAR: begin
          state_r <= IFP_IDLE;
        end
      endcase
    end
  end

  // read latency counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_cnt_r <= 2'h0;
    end else if (state_r == IFP_READ) begin
      rd_cnt_r <= rd_cnt_r + 2'h1;
    end else begin
      rd_cnt_r <= 2'h0;
    end
  end

  // main control register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= 3'h0;
      rd_en_r <= 1'b0;
      wr_start_r <= 1'b0;
      rd_start_r <= 1'b0;
    end else begin
      if (w_ctrl) begin
        mode_r <= bus.wdata[6:4];
        rd_en_r <= bus.wdata[ifp_pkg::BIT_RD_EN];
      end
      if (state_r == IFP_IDLE) begin
        wr_start_r <= go_erase | go_write; // [RQ4]
        rd_start_r <= go_read; // [RQ6]
      end else if ((state_r == IFP_ERASE || state_r == IFP_WRITE) && tmr_expired && !arr_busy) begin
        wr_start_r <= 1'b0; // [RQ4] [RQ26]
      end else if (state_r == IFP_READ && rd_cnt_r == 2'(ifp_pkg::READ_CYC - 1)) begin
        rd_start_r <= 1'b0; // [RQ6]
      end
    end
  end

  // erase/write enable flag and unlock trigger
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ew_en_r <= 1'b0;
      unlock_r <= 1'b0;
      ulk_cnt_r <= 7'h0;
    end else begin
      if (unlock_r) begin
        ulk_cnt_r <= ulk_cnt_r + 7'h1;
        if (ulk_cnt_r == 7'(ifp_pkg::UNLOCK_CYC - 1)) begin
          unlock_r <= 1'b0; // [RQ16]
          if (key_ok) begin
            ew_en_r <= 1'b1; // [RQ3] [RQ18]
          end
        end
      end else if (w_ctrl && bus.wdata[ifp_pkg::BIT_UNLOCK] && bus.wdata[6:4] == ifp_pkg::MODE_UNLOCK) begin
        unlock_r <= 1'b1; // [RQ16]
        ulk_cnt_r <= 7'h0;
      end
      // software may only clear the flag; hardware set wins
      if (w_ctrl && !bus.wdata[ifp_pkg::BIT_EW_EN] &&
          !(unlock_r && ulk_cnt_r == 7'(ifp_pkg::UNLOCK_CYC - 1) && key_ok)) begin
        ew_en_r <= 1'b0; // [RQ13]
      end
    end
  end

  // aux control, chip reset key
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tsel_r <= 1'b0;
      buf_clr_r <= 1'b0;
      chip_key_r <= ifp_pkg::RST_BYTE;
      chip_rst_r <= 1'b0;
    end else begin
      if (w_aux) begin
        tsel_r <= bus.wdata[ifp_pkg::BIT_TSEL];
      end
      if (state_r == IFP_CLEAR) begin
        buf_clr_r <= 1'b0; // [RQ8]
      end else if (w_aux && state_r == IFP_IDLE) begin
        buf_clr_r <= bus.wdata[ifp_pkg::BIT_BUF_CLR];
      end
      if (bus.wr && bus.addr == ifp_pkg::ADDR_CHIP_RST) begin
        chip_key_r <= bus.wdata;
      end
      chip_rst_r <= bus.wr & (bus.addr == ifp_pkg::ADDR_CHIP_RST) & (bus.wdata == ifp_pkg::CHIP_RST_KEY); // [RQ23]
    end
  end

  // address register with page-bounded auto increment
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 12'h000;
    end else if (bus.wr && bus.addr == ifp_pkg::ADDR_ADR_LO) begin
      addr_r[7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == ifp_pkg::ADDR_ADR_HI) begin
      addr_r[11:8] <= bus.wdata[3:0];
    end else if (w_hi0 && ew_en_r && state_r == IFP_IDLE && addr_r[4:0] != 5'h1f) begin
      addr_r[4:0] <= addr_r[4:0] + 5'h1; // [RQ9] [RQ10] [RQ7]
    end
  end

  // data register pairs; read result lands in pair zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        dat_lo_r[i] <= ifp_pkg::RST_BYTE;
        dat_hi_r[i] <= ifp_pkg::RST_BYTE;
      end
    end else if (state_r == IFP_READ && rd_cnt_r == 2'(ifp_pkg::READ_CYC - 1)) begin
      dat_lo_r[0] <= arr_rdata[7:0]; // [RQ25]
      dat_hi_r[0] <= arr_rdata[15:8]; // [RQ25]
    end else if (bus.wr && bus.addr >= ifp_pkg::ADDR_DAT0_LO && bus.addr <= ifp_pkg::ADDR_DAT3_HI) begin
      if (bus.addr[0]) begin
        dat_lo_r[2'((bus.addr - ifp_pkg::ADDR_DAT0_LO) >> 1)] <= bus.wdata;
      end else begin
        dat_hi_r[2'((bus.addr - ifp_pkg::ADDR_DAT0_LO) >> 1)] <= bus.wdata;
      end
    end
  end

  // page write buffer and erase tags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ifp_pkg::PAGE_WORDS; i++) begin
        wbuf_r[i] <= 16'h0000;
      end
      tag_r <= 32'h0;
    end else if (state_r == IFP_CLEAR || (state_r == IFP_WRITE && tmr_expired && !arr_busy)) begin
      for (int i = 0; i < ifp_pkg::PAGE_WORDS; i++) begin
        wbuf_r[i] <= 16'h0000; // [RQ8] [RQ11]
      end
      tag_r <= 32'h0;
    end else if (state_r == IFP_ERASE && tmr_expired && !arr_busy) begin
      tag_r <= 32'h0;
    end else if (w_hi0 && ew_en_r && state_r == IFP_IDLE) begin
      wbuf_r[addr_r[4:0]] <= {bus.wdata, dat_lo_r[0]}; // [RQ3] [RQ9] [RQ1]
      tag_r[addr_r[4:0]] <= 1'b1; // [RQ24]
    end
  end

  // flash array drive: buffer streamed word by word during write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_r <= '0;
      wdata_r <= 16'h0000;
      ptr_r <= 5'h0;
    end else begin
      req_r.erase <= (state_r == IFP_ERASE) & ~(tmr_expired & ~arr_busy); // [RQ26]
      req_r.prog <= (state_r == IFP_WRITE) & ~(tmr_expired & ~arr_busy); // [RQ26]
      req_r.read <= (state_r == IFP_READ) & (rd_cnt_r != 2'(ifp_pkg::READ_CYC - 1)); // [RQ20]
      if (state_r == IFP_WRITE) begin
        ptr_r <= ptr_r + 5'h1;
        req_r.addr <= {addr_r[11:5], ptr_r}; // [RQ7] [RQ1]
        wdata_r <= wbuf_r[ptr_r];
      end else begin
        ptr_r <= 5'h0;
        req_r.addr <= addr_r;
        wdata_r <= 16'h0000;
      end
    end
  end

  // cpu stall while an operation runs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stall_r <= 1'b0;
    end else if (state_r == IFP_IDLE) begin
      stall_r <= go_erase | go_write | go_read; // [RQ20]
    end else if (state_r != IFP_CLEAR) begin
      stall_r <= ~(((state_r == IFP_ERASE || state_r == IFP_WRITE) && tmr_expired && !arr_busy) ||
        (state_r == IFP_READ && rd_cnt_r == 2'(ifp_pkg::READ_CYC - 1))); // [RQ20]
    end else begin
      stall_r <= 1'b0;
    end
  end

  // registered read mux
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      unique case (rd_addr)
        ifp_pkg::ADDR_CTRL_MAIN: rd_data_r <= {ew_en_r, mode_r, unlock_r, wr_start_r, rd_en_r, rd_start_r};
        ifp_pkg::ADDR_CHIP_RST: rd_data_r <= chip_key_r;
        ifp_pkg::ADDR_CTRL_AUX: rd_data_r <= {6'h00, tsel_r, buf_clr_r};
        ifp_pkg::ADDR_ADR_LO: rd_data_r <= addr_r[7:0];
        ifp_pkg::ADDR_ADR_HI: rd_data_r <= {4'h0, addr_r[11:8]};
        ifp_pkg::ADDR_DAT0_LO: rd_data_r <= dat_lo_r[0];
        ifp_pkg::ADDR_DAT0_HI: rd_data_r <= dat_hi_r[0];
        ifp_pkg::ADDR_DAT1_LO: rd_data_r <= dat_lo_r[1];
        ifp_pkg::ADDR_DAT1_HI: rd_data_r <= dat_hi_r[1];
        ifp_pkg::ADDR_DAT2_LO: rd_data_r <= dat_lo_r[2];
        ifp_pkg::ADDR_DAT2_HI: rd_data_r <= dat_hi_r[2];
        ifp_pkg::ADDR_DAT3_LO: rd_data_r <= dat_lo_r[3];
        ifp_pkg::ADDR_DAT3_HI: rd_data_r <= dat_hi_r[3];
        default: rd_data_r <= 8'h00;
      endcase
    end
  end

  assign rd_data = rd_data_r;
  assign cpu_stall = stall_r;
  assign chip_rst_req = chip_rst_r;
  assign arr_req = req_r;
  assign arr_wdata = wdata_r;
  assign arr_tag = tag_r;
endmodule

// File: logic/ifp_pkg.sv
// package for the in-application flash programming controller
package ifp_pkg;
  // register indices on the cpu data-memory port
  localparam logic [3:0] ADDR_CTRL_MAIN = 4'h0;
  localparam logic [3:0] ADDR_CHIP_RST = 4'h1;
  localparam logic [3:0] ADDR_CTRL_AUX = 4'h2;
  localparam logic [3:0] ADDR_ADR_LO = 4'h3;
  localparam logic [3:0] ADDR_ADR_HI = 4'h4;
  localparam logic [3:0] ADDR_DAT0_LO = 4'h5;
  localparam logic [3:0] ADDR_DAT0_HI = 4'h6;
  localparam logic [3:0] ADDR_DAT1_LO = 4'h7;
  localparam logic [3:0] ADDR_DAT1_HI = 4'h8;
  localparam logic [3:0] ADDR_DAT2_LO = 4'h9;
  localparam logic [3:0] ADDR_DAT2_HI = 4'ha;
  localparam logic [3:0] ADDR_DAT3_LO = 4'hb;
  localparam logic [3:0] ADDR_DAT3_HI = 4'hc;
  // main control field positions
  localparam int BIT_EW_EN = 7;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_UNLOCK = 3;
  localparam int BIT_WR_START = 2;
  localparam int BIT_RD_EN = 1;
  localparam int BIT_RD_START = 0;
  // aux control field positions
  localparam int BIT_TSEL = 1;
  localparam int BIT_BUF_CLR = 0;
  // mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // reset values and keys
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CHIP_RST_KEY = 8'h55;
  localparam logic [7:0] KEY_D1L = 8'h00;
  localparam logic [7:0] KEY_D2L = 8'h0d;
  localparam logic [7:0] KEY_D3L = 8'hc3;
  localparam logic [7:0] KEY_D1H = 8'h04;
  localparam logic [7:0] KEY_D2H = 8'h09;
  localparam logic [7:0] KEY_D3H = 8'h40;
  // timing at the 20 MHz core clock
  localparam int CLK_NS = 50;
  localparam int ERASE_US_FAST = 3200;
  localparam int WRITE_US_FAST = 2200;
  localparam int ERASE_US_SLOW = 3700;
  localparam int WRITE_US_SLOW = 3000;
  localparam int ERASE_CYC_FAST = (ERASE_US_FAST * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC_FAST = (WRITE_US_FAST * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC_SLOW = (ERASE_US_SLOW * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC_SLOW = (WRITE_US_SLOW * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int UNLOCK_CYC = 64;
  localparam int READ_CYC = 2;
  localparam int PAGE_WORDS = 32;
  // cpu register port
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ifp_bus_t;
  // flash array port
  typedef struct packed {
    logic erase;
    logic prog;
    logic read;
    logic [11:0] addr;
  } ifp_arr_req_t;
endpackage

// File: logic/ifp_op_timer.sv
// minimum-duration down counter for flash operations
`timescale 1ns/10ps
module ifp_op_timer #(
  parameter int W = 18
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] count,
  // status
  output logic expired
);
  logic [W-1:0] cnt_r;

  // load and count down to zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == '0) & ~load;
endmodule

// File: tb/ifp_flash_model.sv
// behavioural flash array answering erase, program and read
`timescale 1ns/10ps
module ifp_flash_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // array port
  input wire ifp_pkg::ifp_arr_req_t arr_req,
  input wire logic [7:0] busy_cyc,
  output logic arr_busy,
  output logic [15:0] arr_rdata
);
  logic [7:0] cnt_r;
  logic op_d_r;
  logic tog_r;
  // busy window opened by each erase or program start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
      op_d_r <= 1'b0;
    end else begin
      op_d_r <= arr_req.erase | arr_req.prog;
      if ((arr_req.erase | arr_req.prog) && !op_d_r) cnt_r <= busy_cyc;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end
  // idle pattern flips every cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end
  // one word per read, derived from its address
  assign arr_busy = cnt_r != 8'h00;
  assign arr_rdata = arr_req.read ? {4'h5, arr_req.addr} : {16{tog_r}};
endmodule

// File: tb/ifp_ctrl_asserts.sv
// checker for the flash programming controller ports
`timescale 1ns/10ps
module ifp_ctrl_asserts #(
  parameter int ERASE_FAST = 20,
  parameter int WRITE_FAST = 30,
  parameter int ERASE_SLOW = 40,
  parameter int WRITE_SLOW = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // cpu side
  input wire ifp_pkg::ifp_bus_t bus,
  input wire logic [3:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic cpu_stall,
  input wire logic chip_rst_req,
  // array side
  input wire ifp_pkg::ifp_arr_req_t arr_req,
  input wire logic [15:0] arr_wdata,
  input wire logic [31:0] arr_tag,
  input wire logic arr_busy,
  input wire logic [15:0] arr_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [19:0] op_cnt_r;
  // length of the running erase or program request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) op_cnt_r <= 20'h0;
    else if (arr_req.erase | arr_req.prog) op_cnt_r <= op_cnt_r + 20'h1;
    else op_cnt_r <= 20'h0;
  end
  chk_rst_pulse: assert property (
    bus.wr && bus.addr == ifp_pkg::ADDR_CHIP_RST && bus.wdata == ifp_pkg::CHIP_RST_KEY |=> chip_rst_req)
    else $error("no reset pulse after key write");
  chk_rst_cause: assert property (
    chip_rst_req |-> $past(bus.wr && bus.addr == ifp_pkg::ADDR_CHIP_RST && bus.wdata == ifp_pkg::CHIP_RST_KEY))
    else $error("reset pulse without key write");
  chk_stall_op: assert property (
    arr_req.erase || arr_req.prog || arr_req.read |-> cpu_stall)
    else $error("array busy without cpu stall");
  chk_end_busy: assert property (
    $fell(arr_req.erase || arr_req.prog) |-> !$past(arr_busy))
    else $error("operation ended while array busy");
  chk_erase_time: assert property (
    $fell(arr_req.erase) |-> op_cnt_r >= ERASE_FAST - 2)
    else $error("erase too short");
  chk_write_time: assert property (
    $fell(arr_req.prog) |-> op_cnt_r >= WRITE_FAST - 2)
    else $error("write too short");
  chk_read_short: assert property (
    $rose(arr_req.read) |-> ##[1:3] !cpu_stall)
    else $error("read did not finish");
  chk_read_gate: assert property (
    bus.wr && bus.addr == ifp_pkg::ADDR_CTRL_MAIN && bus.wdata[2:0] == 3'h1 && !cpu_stall |=> !cpu_stall [*3])
    else $error("read ran without read enable");
  chk_tag_clear: assert property (
    $fell(arr_req.erase) |-> ##[0:2] arr_tag == 32'h0)
    else $error("erase tags not cleared");
  chk_one_op: assert property (
    $onehot0({arr_req.erase, arr_req.prog, arr_req.read}))
    else $error("two array operations at once");
endmodule
bind ifp_ctrl ifp_ctrl_asserts #(.ERASE_FAST(ERASE_FAST), .WRITE_FAST(WRITE_FAST), .ERASE_SLOW(ERASE_SLOW),
  .WRITE_SLOW(WRITE_SLOW)) i_chk (.core_clk(core_clk), .arst_n(arst_n), .bus(bus), .rd_addr(rd_addr),
  .rd_data(rd_data), .cpu_stall(cpu_stall), .chip_rst_req(chip_rst_req), .arr_req(arr_req),
  .arr_wdata(arr_wdata), .arr_tag(arr_tag), .arr_busy(arr_busy), .arr_rdata(arr_rdata));

// File: tb/tb_top.sv
// register-level testbench for the flash programming controller
`timescale 1ns/10ps
module tb_top;
  localparam int EF = 20;
  localparam int WF = 40;
  localparam int ES = 40;
  localparam int WS = 50;
  logic core_clk;
  logic arst_n;
  ifp_pkg::ifp_bus_t bus;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic cpu_stall;
  logic chip_rst_req;
  ifp_pkg::ifp_arr_req_t arr_req;
  logic [15:0] arr_wdata;
  logic [31:0] arr_tag;
  logic arr_busy;
  logic [15:0] arr_rdata;
  logic [7:0] busy_cyc;
  logic seen;
  int n_errors;
  int n_checks;
  int n_rst;
  int n;
  int i;
  ifp_ctrl #(.ERASE_FAST(EF), .WRITE_FAST(WF), .ERASE_SLOW(ES), .WRITE_SLOW(WS)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .bus(bus), .rd_addr(rd_addr), .rd_data(rd_data),
    .cpu_stall(cpu_stall), .chip_rst_req(chip_rst_req), .arr_req(arr_req), .arr_wdata(arr_wdata),
    .arr_tag(arr_tag), .arr_busy(arr_busy), .arr_rdata(arr_rdata));
  ifp_flash_model i_mem (.core_clk(core_clk), .arst_n(arst_n), .arr_req(arr_req), .busy_cyc(busy_cyc),
    .arr_busy(arr_busy), .arr_rdata(arr_rdata));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // watch the program stream and reset pulses
  always @(posedge core_clk) begin
    if (arr_req.prog === 1'b1 && arr_wdata === 16'h5aa5) seen <= 1'b1;
    if (chip_rst_req === 1'b1) n_rst <= n_rst + 1;
  end
  task automatic chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    n_checks++;
    if (sv !== ev) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= {1'b1, a, d};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    rd_addr <= a;
    @(posedge core_clk);
    #1 chk(nm, rd_data, e);
  endtask
  // start an operation and count stalled cycles
  task automatic run(input logic [7:0] ctl, output int c);
    wr(4'h0, ctl);
    c = 0;
    repeat (2) @(posedge core_clk);
    #1;
    while (cpu_stall === 1'b1 && c < 500) begin
      @(posedge core_clk);
      #1 c++;
    end
    chk("stall limit", c < 500, 1);
  endtask
  task automatic unlock(input logic [7:0] k);
    wr(4'h0, 8'h68);
    wr(4'h7, ifp_pkg::KEY_D1L);
    wr(4'h9, ifp_pkg::KEY_D2L);
    wr(4'hb, k);
    wr(4'h8, ifp_pkg::KEY_D1H);
    wr(4'ha, ifp_pkg::KEY_D2H);
    wr(4'hc, ifp_pkg::KEY_D3H);
    rd(4'h0, 8'h68, "unlock running");
    repeat (64) @(posedge core_clk);
  endtask
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    bus = '0;
    rd_addr = 4'h0;
    busy_cyc = 8'h04;
    seen = 1'b0;
    n_errors = 0;
    n_checks = 0;
    n_rst = 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    for (i = 0; i < 14; i++) rd(i[3:0], 8'h00, "reset value");
    run(8'h84, n);
    chk("locked write", n, 0);
    rd(4'h0, 8'h00, "set enable");
    wr(4'h3, 8'h20);
    wr(4'h4, 8'h01);
    wr(4'h6, 8'h11);
    rd(4'h3, 8'h20, "locked load");
    unlock(8'h00);
    rd(4'h0, 8'h60, "bad key");
    unlock(ifp_pkg::KEY_D3L);
    rd(4'h0, 8'he0, "unlocked");
    rd(4'hb, 8'hc3, "key reg");
    wr(4'h1, 8'h54);
    wr(4'h1, 8'h55);
    rd(4'h1, 8'h55, "reset key reg");
    chk("reset pulses", n_rst, 1);
    run(8'ha4, n);
    chk("reserved mode", n, 0);
    wr(4'h3, 8'h20);
    wr(4'h6, 8'h00);
    wr(4'h6, 8'h00);
    rd(4'h3, 8'h22, "addr step");
    chk("tags", arr_tag, 32'h3);
    run(8'h94, n);
    chk("erase fast", n >= EF - 2 && n <= EF + 4, 1);
    rd(4'h0, 8'h90, "erase done");
    chk("tags clear", arr_tag, 32'h0);
    wr(4'h3, 8'h3e);
    wr(4'h5, 8'ha5);
    for (i = 0; i < 3; i++) wr(4'h6, 8'h5a);
    rd(4'h3, 8'h3f, "addr hold");
    rd(4'h4, 8'h01, "page kept");
    seen <= 1'b0;
    run(8'h84, n);
    chk("write fast", n >= WF - 2 && n <= WF + 4, 1);
    chk("stream", seen, 1);
    rd(4'h0, 8'h80, "write done");
    seen <= 1'b0;
    run(8'h84, n);
    chk("auto clear", seen, 0);
    wr(4'h3, 8'h20);
    wr(4'h6, 8'h5a);
    wr(4'h2, 8'h01);
    rd(4'h2, 8'h00, "clear bit");
    seen <= 1'b0;
    run(8'h84, n);
    chk("manual clear", seen, 0);
    wr(4'h2, 8'h02);
    run(8'h94, n);
    chk("erase slow", n >= ES - 2 && n <= ES + 4, 1);
    run(8'h84, n);
    chk("write slow", n >= WS - 2 && n <= WS + 4, 1);
    wr(4'h2, 8'h00);
    @(posedge core_clk);
    busy_cyc <= 8'h5a;
    run(8'h94, n);
    chk("busy hold", n >= 88, 1);
    wr(4'h3, 8'h23);
    run(8'hb1, n);
    chk("read gated", n, 0);
    run(8'hb3, n);
    rd(4'h0, 8'hb2, "read done");
    rd(4'h5, 8'h23, "read low");
    rd(4'h6, 8'h51, "read high");
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00, "disable");
    wr(4'h6, 8'h00);
    rd(4'h3, 8'h23, "load disabled");
    complete_run();
  end
endmodule
